// [hdl/shc_slot_control.sv]
/*
 parallel hot plug slot control for one downstream port, with its slot
 capability, slot control/status and user configuration words on AXI4-Lite.
 assumes slot inputs already synchronous to aclk and one AXI master.
*/
// Functional notes
// - latch input active low, gated by capability
// - closed latch: power, indicator, clock, release reset
// - debounced latch change sets changed status
// - latch interrupt needs its enable and global
// - one interrupt method per port, exclusive
// - latch opens when powered: clock off, power off
// - debounce latch and presence inputs; first latch sample after reset raw
// - power control bit drives slot reset
// - presence change latched, interrupt when enabled
// - power enable active high, needs controller present
// - power control write raises command completed
// - low fault level latched, interrupt when enabled
// - fault status set only with power controller present
// - clock enable waits for power good when delay field is zero
// - power good polarity bit inverts sense
// - nonzero delay field: fixed clock delay
// - indicator from control field, write completes command
// - latch sensor enabled by default
// - clock enable active low, follows power control
// - delay field resets to power good mode
`timescale 1ns/10ps
module shc_slot_control #(
   parameter int DEBOUNCE_CYCLES = shc_pkg::DEBOUNCE_CYC,
   parameter int DELAY_UNIT_CYCLES = shc_pkg::DELAY_UNIT_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic latch_sensor_n,
   input wire logic slot_presence_n,
   input wire logic slot_power_fault_n,
   input wire logic slot_power_good,
   output logic slot_power_enable,
   output logic slot_clock_enable_n,
   output logic slot_reset_n,
   output logic power_indicator_n,
   output logic msi_request,
   output logic intx_assert,
   output logic intx_deassert,
   output logic switch_interrupt_pin_n
);
   localparam logic [shc_pkg::DB_W-1:0] DB_LAST = shc_pkg::DB_W'(DEBOUNCE_CYCLES - 1);
   localparam logic [shc_pkg::CNT_W-1:0] UNIT = shc_pkg::CNT_W'(DELAY_UNIT_CYCLES);
   localparam logic [shc_pkg::CNT_W-1:0] GAP_LAST = shc_pkg::CNT_W'(shc_pkg::STEP_GAP_CYC - 1);

   function automatic logic [1:0] reg_sel(input logic [11:0] a);
      reg_sel = 2'h0;
      if (a[11:2] == shc_pkg::CAP_OFS[11:2]) reg_sel = 2'h1;
      if (a[11:2] == shc_pkg::CTL_OFS[11:2]) reg_sel = 2'h2;
      if (a[11:2] == shc_pkg::CFG_OFS[11:2]) reg_sel = 2'h3;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb, input logic [31:0] wmask);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
      merge = (old & ~m) | (d & m);
   endfunction

   logic [31:0] cap;
   logic [31:0] ctl;
   logic [31:0] cfg;
   logic aw_full;
   logic w_full;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [1:0] wsel;
   logic st_flt;
   logic st_latch;
   logic st_prs;
   logic st_cc;
   logic started;
   shc_pkg::shc_sense_t raw;
   shc_pkg::shc_sense_t stable;
   logic [1:0] db_flip;
   logic [shc_pkg::DB_W-1:0] db_cnt [2];
   shc_pkg::shc_state_t state;
   shc_pkg::shc_state_t next_state;
   logic [shc_pkg::CNT_W-1:0] cnt;
   logic [shc_pkg::CNT_W-1:0] dly_target;
   logic [1:0] dly;
   logic pwr_ok;
   logic latch_ok;
   logic want_on;
   logic pg_ok;
   logic pend;
   logic pend_q;
   logic [1:0] method;
   logic ctl_wr;
   logic [31:0] ctl_word;

   // write side: address and data taken in either order, answer after both
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign wsel = reg_sel(aw_addr);
   assign ctl_wr = do_write && wsel == 2'h2;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= shc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == 2'h0) ? shc_pkg::RESP_SLVERR : shc_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration words; normally loaded at start-up by the nonvolatile loader
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap <= shc_pkg::CAP_RST;
         ctl <= shc_pkg::CTL_RST;
         cfg <= shc_pkg::CFG_RST;
      end else if (do_write) begin
         if (wsel == 2'h1) cap <= merge(cap, w_data, w_strb, shc_pkg::CAP_WMASK);
         if (wsel == 2'h2) ctl <= merge(ctl, w_data, w_strb, shc_pkg::CTL_WMASK);
         if (wsel == 2'h3) cfg <= merge(cfg, w_data, w_strb, shc_pkg::CFG_WMASK);
      end
   end

   // read side: one outstanding read, unmapped reads zero with slverr
   assign s_axi_arready = !s_axi_rvalid;
   assign ctl_word = {9'h000, stable.present, stable.latch_open, st_cc, st_prs, st_latch, st_flt,
                      1'b0, ctl[15:0]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= shc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= shc_pkg::RESP_OKAY;
         case (reg_sel(s_axi_araddr))
            2'h1: s_axi_rdata <= cap;
            2'h2: s_axi_rdata <= ctl_word;
            2'h3: s_axi_rdata <= cfg;
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= shc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // debounce of latch and presence; first sample after reset taken raw
   assign raw.latch_open = latch_sensor_n;
   assign raw.present = !slot_presence_n;

   always_ff @(posedge aclk) begin
      if (!aresetn) started <= 1'b0;
      else started <= 1'b1;
   end

   generate
      for (genvar i = 0; i < 2; i++) begin : g_db
         assign db_flip[i] = started && raw[i] != stable[i] && db_cnt[i] == DB_LAST;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               stable[i] <= 1'b0;
               db_cnt[i] <= '0;
            end else if (!started) begin
               stable[i] <= raw[i];
               db_cnt[i] <= '0;
            end else if (raw[i] == stable[i] || db_flip[i]) begin
               stable[i] <= raw[i];
               db_cnt[i] <= '0;
            end else begin
               db_cnt[i] <= db_cnt[i] + 1'b1;
            end
         end
      end
   endgenerate

   // changed bits: hardware set wins over a write-one clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_flt <= 1'b0;
         st_latch <= 1'b0;
         st_prs <= 1'b0;
         st_cc <= 1'b0;
      end else begin
         st_flt <= (st_flt & ~(ctl_wr & w_strb[2] & w_data[shc_pkg::ST_FLT]))
                   | (cap[shc_pkg::CAP_PWR] & !slot_power_fault_n);
         st_latch <= (st_latch & ~(ctl_wr & w_strb[2] & w_data[shc_pkg::ST_LATCH]))
                     | (cap[shc_pkg::CAP_LATCH] & db_flip[0]);
         st_prs <= (st_prs & ~(ctl_wr & w_strb[2] & w_data[shc_pkg::ST_PRS])) | db_flip[1];
         st_cc <= (st_cc & ~(ctl_wr & w_strb[2] & w_data[shc_pkg::ST_CC]))
                  | (ctl_wr & w_strb[1]);
      end
   end

   // slot power sequencer
   assign pwr_ok = cap[shc_pkg::CAP_PWR];
   assign latch_ok = !cap[shc_pkg::CAP_LATCH] || !stable.latch_open;
   assign want_on = pwr_ok && latch_ok && !ctl[shc_pkg::CTL_PCC];
   assign pg_ok = slot_power_good ^ cfg[shc_pkg::CFG_PG_LOW];
   assign dly = cfg[shc_pkg::CFG_DLY_LO +: 2];

   always_comb begin
      case (dly)
         2'h1: dly_target = UNIT;
         2'h2: dly_target = UNIT << 1;
         default: dly_target = UNIT << 2;
      endcase
   end

   always_comb begin
      next_state = state;
      case (state)
         shc_pkg::S_OFF: if (want_on) next_state = shc_pkg::S_PWR_UP;
         shc_pkg::S_PWR_UP: begin
            if (!want_on) next_state = shc_pkg::S_OFF;
            else if (dly == shc_pkg::DLY_PG ? pg_ok : cnt == dly_target)
               next_state = shc_pkg::S_CLK_UP;
         end
         shc_pkg::S_CLK_UP: begin
            if (!want_on) next_state = shc_pkg::S_CLK_DOWN;
            else if (cnt == GAP_LAST) next_state = shc_pkg::S_RUN;
         end
         shc_pkg::S_RUN: if (!want_on) next_state = shc_pkg::S_CLK_DOWN;
         shc_pkg::S_CLK_DOWN: if (cnt == GAP_LAST) next_state = shc_pkg::S_OFF;
         default: next_state = shc_pkg::S_OFF;
      endcase
      if (!pwr_ok) next_state = shc_pkg::S_OFF;
      // stay off until the first raw latch sample replaces the reset default of stable
      if (!started) next_state = shc_pkg::S_OFF;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= shc_pkg::S_OFF;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= (next_state != state) ? '0 : cnt + 1'b1;
      end
   end

   // registered slot outputs; power, clock and indicator off and slot reset asserted while the switch is in reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_power_enable <= 1'b0;
         slot_clock_enable_n <= 1'b1;
         slot_reset_n <= 1'b0;
         power_indicator_n <= 1'b1;
      end else begin
         slot_power_enable <= next_state != shc_pkg::S_OFF;
         slot_clock_enable_n <= !(next_state == shc_pkg::S_CLK_UP || next_state == shc_pkg::S_RUN);
         slot_reset_n <= next_state == shc_pkg::S_RUN;
         // blink is shown steady: no blink timer is kept
         power_indicator_n <= !(cap[shc_pkg::CAP_IND] && next_state != shc_pkg::S_OFF
                                && ctl[shc_pkg::CTL_IND_LO +: 2] != shc_pkg::IND_OFF);
      end
   end

   // interrupt request, level while any enabled changed bit stays set
   assign pend = ctl[shc_pkg::CTL_HPI_EN] && ((st_flt && ctl[shc_pkg::CTL_FLT_EN])
                 || (st_latch && ctl[shc_pkg::CTL_LATCH_EN]) || (st_prs && ctl[shc_pkg::CTL_PRS_EN])
                 || (st_cc && ctl[shc_pkg::CTL_CC_EN]));
   assign method = cfg[shc_pkg::CFG_INT_LO +: 2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_q <= 1'b0;
         msi_request <= 1'b0;
         intx_assert <= 1'b0;
         intx_deassert <= 1'b0;
         switch_interrupt_pin_n <= 1'b1;
      end else begin
         pend_q <= pend;
         msi_request <= method == shc_pkg::INT_MSI && pend && !pend_q;
         intx_assert <= method == shc_pkg::INT_INTX && pend && !pend_q;
         intx_deassert <= method == shc_pkg::INT_INTX && !pend && pend_q;
         switch_interrupt_pin_n <= !(method == shc_pkg::INT_PIN && pend);
      end
   end

   latch_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(slot_reset_n) |-> $past(latch_ok) && $past(pwr_ok))
      else $error("slot reset released without closed latch");
   clk_after_pwr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(slot_clock_enable_n) |-> slot_power_enable && $past(slot_power_enable))
      else $error("clock enabled before power");
   reset_after_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(slot_reset_n) |-> !slot_clock_enable_n && $past(!slot_clock_enable_n, 2))
      else $error("reset released before clock settled");
   auto_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == shc_pkg::S_RUN && pwr_ok && cap[shc_pkg::CAP_LATCH] && stable.latch_open
      |=> slot_clock_enable_n && slot_power_enable && !slot_reset_n)
      else $error("latch open did not drop clock first");
   latch_chg_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cap[shc_pkg::CAP_LATCH] && db_flip[0] |=> st_latch ##1 st_latch || $past(ctl_wr))
      else $error("latch change not latched");
   pin_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
      method == shc_pkg::INT_PIN && pend |=> !switch_interrupt_pin_n)
      else $error("interrupt pin not driven while pending");
   pwr_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !pwr_ok |=> !slot_power_enable && slot_clock_enable_n)
      else $error("slot powered without power controller");
   clk_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == shc_pkg::S_PWR_UP && want_on && dly != shc_pkg::DLY_PG && cnt < dly_target
      |=> slot_clock_enable_n)
      else $error("clock enabled before fixed delay");
   cmd_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctl_wr && w_strb[1] |=> st_cc)
      else $error("command completed not set");
   reset_hold_a: assert property (@(posedge aclk)
      !aresetn |=> !slot_power_enable && slot_clock_enable_n && !slot_reset_n && power_indicator_n)
      else $error("slot outputs active in reset");
   first_sample_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !started |=> stable == $past(raw) && !st_latch && !st_prs)
      else $error("first slot sample not taken raw");
   start_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !started |=> !slot_power_enable && !slot_reset_n)
      else $error("slot outputs moved before first sample");
   pg_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == shc_pkg::S_PWR_UP && dly == shc_pkg::DLY_PG && !pg_ok |=> slot_clock_enable_n)
      else $error("clock enabled before power good");
endmodule

// [hdl/shc_pkg.sv]
/*
 package for the slot hot plug controller: register offsets, field positions,
 reset values, timing constants, states and carrier types.
 assumes a 125 MHz core clock and 32-bit AXI4-Lite register access.
*/
package shc_pkg;
   localparam logic [11:0] CAP_OFS = 12'h07c;
   localparam logic [11:0] CTL_OFS = 12'h080;
   localparam logic [11:0] CFG_OFS = 12'hf70;
   localparam int CAP_PWR = 1;
   localparam int CAP_LATCH = 2;
   localparam int CAP_IND = 4;
   localparam int CTL_FLT_EN = 1;
   localparam int CTL_LATCH_EN = 2;
   localparam int CTL_PRS_EN = 3;
   localparam int CTL_CC_EN = 4;
   localparam int CTL_HPI_EN = 5;
   localparam int CTL_IND_LO = 8;
   localparam int CTL_PCC = 10;
   localparam int ST_FLT = 17;
   localparam int ST_LATCH = 18;
   localparam int ST_PRS = 19;
   localparam int ST_CC = 20;
   localparam int CFG_DLY_LO = 3;
   localparam int CFG_PG_LOW = 6;
   localparam int CFG_INT_LO = 8;
   localparam logic [31:0] CAP_RST = 32'h00000016;
   localparam logic [31:0] CTL_RST = 32'h00000100;
   localparam logic [31:0] CFG_RST = 32'h00000000;
   localparam logic [31:0] CAP_WMASK = 32'h00000016;
   localparam logic [31:0] CTL_WMASK = 32'h0000073e;
   localparam logic [31:0] CFG_WMASK = 32'h00000358;
   localparam logic [1:0] IND_OFF = 2'h3;
   localparam logic [1:0] INT_MSI = 2'h0;
   localparam logic [1:0] INT_INTX = 2'h1;
   localparam logic [1:0] INT_PIN = 2'h2;
   localparam logic [1:0] DLY_PG = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CLK_MHZ = 125;
   localparam int DEBOUNCE_MS = 10;
   localparam int DELAY_UNIT_MS = 128;
   localparam int STEP_GAP_US = 1;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_MHZ * 1000;
   localparam int DELAY_UNIT_CYC = DELAY_UNIT_MS * CLK_MHZ * 1000;
   localparam int STEP_GAP_CYC = STEP_GAP_US * CLK_MHZ;
   localparam int CNT_W = 26;
   localparam int DB_W = 21;
   typedef enum logic [2:0] {S_OFF, S_PWR_UP, S_CLK_UP, S_RUN, S_CLK_DOWN} shc_state_t;
   typedef struct packed {
      logic present;
      logic latch_open;
   } shc_sense_t;
endpackage

// [test/shc_slot_model.sv]
/*
 behavioural slot supply for the hot plug bench: answers power enable with
 power good after a lag set by the bench. assumes aclk from the bench.
*/
`timescale 1ns/10ps
module shc_slot_model (
   input wire logic aclk,
   input wire logic slot_power_enable,
   input wire logic [7:0] pg_lag,
   input wire logic pg_active_low,
   output logic slot_power_good
);
   logic [7:0] cnt = 8'h00;
   logic good;
   // lag 8'hff models a supply that never settles, so only a timer can help
   assign good = slot_power_enable && (cnt == pg_lag) && (pg_lag != 8'hff);
   always @(posedge aclk) begin
      if (!slot_power_enable)
         cnt <= 8'h00;
      else if (cnt != pg_lag && cnt != 8'hff)
         cnt <= cnt + 8'h01;
   end
   // polarity changed by the bench only while slot power is off, never while running
   assign slot_power_good = good ^ pg_active_low;
endmodule

// [test/slot_hot_plug_control_tb_top.sv]
/*
 self-checking bench for the slot hot plug controller: axi4-lite master,
 slot inputs and supply model. assumes shc_pkg and a single 125 MHz clock.
*/
`timescale 1ns/10ps
module slot_hot_plug_control_tb_top;
   localparam logic [11:0] CAP = shc_pkg::CAP_OFS;
   localparam logic [11:0] CTL = shc_pkg::CTL_OFS;
   localparam logic [11:0] CFG = shc_pkg::CFG_OFS;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [11:0] s_axi_araddr = 12'h000;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic latch_sensor_n = 1'b0;
   logic pg_low = 1'b0;
   logic slot_presence_n = 1'b0;
   logic slot_power_fault_n = 1'b1;
   logic slot_power_good;
   logic slot_power_enable, slot_clock_enable_n, slot_reset_n, power_indicator_n;
   logic msi_request, intx_assert, intx_deassert, switch_interrupt_pin_n;
   logic [7:0] pg_lag = 8'h1e;
   logic [3:0] outs;
   logic [31:0] rng = 32'ha9459cc9;
   logic [31:0] rd_data;
   logic [1:0] resp;
   int miscompares = 0;
   int check_count = 0;
   int n, n_msi, n_ia, n_id;

   assign outs = {power_indicator_n, slot_reset_n, slot_clock_enable_n, slot_power_enable};
   always #4 aclk = ~aclk;
   always @(posedge aclk) begin
      n_msi += msi_request;
      n_ia += intx_assert;
      n_id += intx_deassert;
   end

   shc_slot_control #(.DEBOUNCE_CYCLES(8), .DELAY_UNIT_CYCLES(20)) u_dut (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .latch_sensor_n,
      .slot_presence_n, .slot_power_fault_n, .slot_power_good, .slot_power_enable,
      .slot_clock_enable_n, .slot_reset_n, .power_indicator_n, .msi_request, .intx_assert,
      .intx_deassert, .switch_interrupt_pin_n);
   shc_slot_model u_model (.aclk, .slot_power_enable, .pg_lag, .pg_active_low(pg_low), .slot_power_good);

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // timer mode: one unit of 20 cycles doubled per step of the field
   function automatic int dly(input int s);
      return 20 << (s - 1);
   endfunction
   function automatic logic [2:0] irq_exp(input int m);
      return {m == 0, m == 1, m == 2};
   endfunction

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // random answer latency on the master side: 0 to 3 cycles
   task automatic rnd_wait;
      rng = xs(rng);
      repeat (rng[1:0]) @(posedge aclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      rnd_wait;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!(s_axi_bvalid && s_axi_bready));
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      rnd_wait;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!(s_axi_rvalid && s_axi_rready));
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // clears all four changed bits without touching the control byte
   task automatic clr;
      wr(CTL, 32'h001e0000, 4'h4);
   endtask
   task automatic wt(input int i, input logic v, input int lim);
      n = 0;
      while (outs[i] !== v && n < lim) begin
         @(posedge aclk);
         n++;
      end
      chk(outs[i], v);
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      report_and_stop;
   end

   initial begin
      repeat (3) @(posedge aclk);
      chk(outs, 4'b1010);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      wt(0, 1'b1, 20);
      chk(power_indicator_n, 1'b0);
      wt(1, 1'b0, 100);
      chk(n > 27, 1);
      chk(slot_power_good, 1'b1);
      wt(2, 1'b1, 200);
      chk(n > 122 && n < 128, 1);
      rd(CAP);
      chk(rd_data, shc_pkg::CAP_RST);
      rd(CFG);
      chk(rd_data, 32'h0);
      rd(CTL);
      chk(rd_data[15:0], 16'h0100);
      rd(12'h084);
      chk(rd_data, 32'h0);
      chk(resp, shc_pkg::RESP_SLVERR);
      wr(12'h088, 32'hffffffff, 4'hf);
      chk(resp, shc_pkg::RESP_SLVERR);
      for (int m = 0; m < 4; m++) begin
         wr(CFG, m << 8, 4'hf);
         clr;
         n_msi = 0;
         n_ia = 0;
         n_id = 0;
         wr(CTL, 32'h00000130, 4'h3);
         repeat (4) @(posedge aclk);
         chk({n_msi == 1, n_ia == 1, !switch_interrupt_pin_n}, irq_exp(m));
         clr;
         repeat (4) @(posedge aclk);
         chk({n_id == 1, switch_interrupt_pin_n}, {m == 1, 1'b1});
      end
      wr(CFG, 32'h00000200, 4'hf);
      wr(CTL, 32'h00000122, 4'h3);
      clr;
      slot_power_fault_n <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(switch_interrupt_pin_n, 1'b0);
      rd(CTL);
      chk(rd_data[shc_pkg::ST_FLT], 1'b1);
      slot_power_fault_n <= 1'b1;
      clr;
      repeat (4) @(posedge aclk);
      chk(switch_interrupt_pin_n, 1'b1);
      wr(CTL, 32'h00000128, 4'h3);
      clr;
      rng = xs(rng);
      slot_presence_n <= 1'b1;
      repeat (rng[2:0] % 6 + 1) @(posedge aclk);
      slot_presence_n <= 1'b0;
      repeat (12) @(posedge aclk);
      rd(CTL);
      chk(rd_data[shc_pkg::ST_PRS], 1'b0);
      slot_presence_n <= 1'b1;
      repeat (12) @(posedge aclk);
      rd(CTL);
      chk({rd_data[shc_pkg::ST_PRS], switch_interrupt_pin_n}, 2'b10);
      slot_presence_n <= 1'b0;
      repeat (12) @(posedge aclk);
      wr(CTL, 32'h00000124, 4'h3);
      clr;
      latch_sensor_n <= 1'b1;
      wt(1, 1'b1, 30);
      chk({slot_power_enable, slot_reset_n}, 2'b10);
      wt(0, 1'b0, 200);
      chk(n > 120, 1);
      rd(CTL);
      chk({rd_data[shc_pkg::ST_LATCH], switch_interrupt_pin_n}, 2'b10);
      clr;
      repeat (4) @(posedge aclk);
      chk(switch_interrupt_pin_n, 1'b1);
      latch_sensor_n <= 1'b0;
      wt(0, 1'b1, 30);
      wt(2, 1'b1, 300);
      clr;
      wr(CTL, 32'h00000500, 4'h3);
      wt(2, 1'b0, 10);
      wt(1, 1'b1, 10);
      wt(0, 1'b0, 200);
      chk(power_indicator_n, 1'b1);
      pg_lag <= 8'hff;
      for (int s = 1; s < 4; s++) begin
         wr(CFG, 32'h00000200 | (s << 3), 4'hf);
         wr(CTL, 32'h00000100, 4'h3);
         wt(0, 1'b1, 20);
         wt(1, 1'b0, 200);
         chk(n > dly(s) - 4 && n < dly(s) + 3, 1);
         wr(CTL, 32'h00000500, 4'h3);
         wt(0, 1'b0, 200);
      end
      wr(CFG, 32'h00000200, 4'hf);
      pg_lag <= 8'h05;
      wr(CTL, 32'h00000100, 4'h3);
      wt(2, 1'b1, 300);
      wr(CTL, 32'h00000300, 4'h3);
      repeat (3) @(posedge aclk);
      chk(power_indicator_n, 1'b1);
      wr(CTL, 32'h00000100, 4'h3);
      repeat (3) @(posedge aclk);
      chk(power_indicator_n, 1'b0);
      wr(CAP, 32'h00000012, 4'hf);
      latch_sensor_n <= 1'b1;
      repeat (20) @(posedge aclk);
      chk(slot_power_enable, 1'b1);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(outs, 4'b1010);
      aresetn <= 1'b1;
      repeat (20) @(posedge aclk);
      chk(outs, 4'b1010);
      rd(CTL);
      chk(rd_data[22:17], 6'h30);
      wr(CFG, 32'h00000040, 4'hf);
      pg_low <= 1'b1;
      pg_lag <= 8'h1e;
      latch_sensor_n <= 1'b0;
      wt(0, 1'b1, 30);
      wt(1, 1'b0, 100);
      chk(n > 27, 1);
      report_and_stop;
   end
endmodule
